// *** hw/gpcn_port.sv ***
// gpcn_port: gpio port with direction, latch, open-drain and change notice
// assumes a one-cycle strobe register port and pins sampled via a synchroniser
`timescale 1ns/10ps
module gpcn_port
#(
	parameter int N = gpcn_pkg::GPCN_PINS
)
(
	input  wire logic                         clk,
	input  wire logic                         nrst,
	input  wire logic [gpcn_pkg::GPCN_AW-1:0] addr,
	input  wire logic [gpcn_pkg::GPCN_DW-1:0] wdata,
	input  wire logic                         wrStb,
	input  wire logic                         rdStb,
	output logic      [gpcn_pkg::GPCN_DW-1:0] rdata,
	input  wire logic [N-1:0]                 pinIn,
	output logic      [N-1:0]                 pinOut,
	output logic      [N-1:0]                 pinOe,
	output logic      [N-1:0]                 pullupEn,
	output logic                              changeIrq
);
	import gpcn_pkg::*;

	// refuse pin counts the registers cannot hold
	if (N < 1 || N > 16)
	begin : g_bad_count
		$error("pin count must be 1..16");
	end

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic hitReg(input logic [GPCN_AW-1:0] a, input logic [7:0] ofs);
		hitReg = (a[7:4] == ofs[7:4]) && (a[1:0] == 2'h0);
	endfunction

	wire logic [1:0] opSel      = addr[3:2];
	wire logic       isBase     = (opSel == ALIAS_BASE);
	wire logic       hitDir     = hitReg(addr, OFS_DIR);
	wire logic       hitLevel   = hitReg(addr, OFS_LEVEL);
	wire logic       hitLatch   = hitReg(addr, OFS_LATCH);
	wire logic       hitOdrain  = hitReg(addr, OFS_ODRAIN);
	wire logic       hitChgCtrl = hitReg(addr, OFS_CHGCTRL);
	wire logic       hitChgEn   = hitReg(addr, OFS_CHGEN);
	wire logic       hitChgPu   = hitReg(addr, OFS_CHGPU);

	// ----------------------------------------
	// pin synchroniser and registers
	// ----------------------------------------
	logic [N-1:0] pinSync;
	logic [N-1:0] dirVal;
	logic [N-1:0] latchVal;
	logic [N-1:0] odVal;
	logic [N-1:0] chgEnVal;
	logic [N-1:0] chgPuVal;
	logic [0:0]   chgOnVal;

	gpcn_sync #(.W(N)) u_sync
	(
		.clk  (clk),
		.nrst (nrst),
		.din  (pinIn),
		.dout (pinSync)
	);

	// direction resets to all inputs
	gpcn_alias_reg #(.W(N), .RSTV(RST_DIR)) u_dir
	(
		.clk   (clk),
		.nrst  (nrst),
		.wrEn  (wrStb && hitDir),
		.opSel (opSel),
		.src   (dirVal),
		.wdata (wdata[N-1:0]),
		.value (dirVal)
	);

	// latch written by its own aliases or by level aliases on the pins
	wire logic         latchWr  = wrStb && (hitLatch || hitLevel);
	wire logic [N-1:0] latchSrc = hitLevel ? pinSync : latchVal;

	gpcn_alias_reg #(.W(N), .RSTV(RST_ZERO)) u_latch
	(
		.clk   (clk),
		.nrst  (nrst),
		.wrEn  (latchWr),
		.opSel (opSel),
		.src   (latchSrc),
		.wdata (wdata[N-1:0]),
		.value (latchVal)
	);

	gpcn_alias_reg #(.W(N), .RSTV(RST_ZERO)) u_odrain
	(
		.clk   (clk),
		.nrst  (nrst),
		.wrEn  (wrStb && hitOdrain),
		.opSel (opSel),
		.src   (odVal),
		.wdata (wdata[N-1:0]),
		.value (odVal)
	);

	gpcn_alias_reg #(.W(1), .RSTV(RST_ZERO)) u_chgon
	(
		.clk   (clk),
		.nrst  (nrst),
		.wrEn  (wrStb && hitChgCtrl),
		.opSel (opSel),
		.src   (chgOnVal),
		.wdata (wdata[CHGCTRL_ON_BIT]),
		.value (chgOnVal)
	);

	gpcn_alias_reg #(.W(N), .RSTV(RST_ZERO)) u_chgen
	(
		.clk   (clk),
		.nrst  (nrst),
		.wrEn  (wrStb && hitChgEn),
		.opSel (opSel),
		.src   (chgEnVal),
		.wdata (wdata[N-1:0]),
		.value (chgEnVal)
	);

	gpcn_alias_reg #(.W(N), .RSTV(RST_ZERO)) u_chgpu
	(
		.clk   (clk),
		.nrst  (nrst),
		.wrEn  (wrStb && hitChgPu),
		.opSel (opSel),
		.src   (chgPuVal),
		.wdata (wdata[N-1:0]),
		.value (chgPuVal)
	);

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	logic [N-1:0] pinOut_q;
	logic [N-1:0] pinOe_q;
	logic [N-1:0] pullupEn_q;
	logic [N-1:0] pinOe_d;
	logic [N-1:0] pinOut_d;

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_pin
			// open-drain drives only the low level
			assign pinOe_d[gi]  = !dirVal[gi] && (!odVal[gi] || !latchVal[gi]);
			assign pinOut_d[gi] = odVal[gi] ? 1'b0 : latchVal[gi];
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pinOut_q   <= '0;
			pinOe_q    <= '0;
			pullupEn_q <= '0;
		end
		else
		begin
			pinOut_q   <= pinOut_d;
			pinOe_q    <= pinOe_d;
			pullupEn_q <= chgPuVal;
		end
	end

	assign pinOut   = pinOut_q;
	assign pinOe    = pinOe_q;
	assign pullupEn = pullupEn_q;

	// ----------------------------------------
	// change notice
	// ----------------------------------------
	logic [N-1:0] pinPrev_q;
	logic         changeIrq_q;
	logic [2:0]   armed_q;

	// hold off until synchroniser and previous sample hold real levels
	wire logic [N-1:0] pinDelta  = (pinSync ^ pinPrev_q) & chgEnVal;
	wire logic         changeHit = chgOnVal[0] && armed_q[2] && |pinDelta;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pinPrev_q   <= '0;
			armed_q     <= 3'h0;
			changeIrq_q <= 1'b0;
		end
		else
		begin
			pinPrev_q   <= pinSync;
			armed_q     <= {armed_q[1:0], 1'b1};
			changeIrq_q <= changeHit;
		end
	end

	assign changeIrq = changeIrq_q;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [GPCN_DW-1:0] rdata_q;
	logic [N-1:0]       rdSel;

	assign rdSel = hitDir    ? dirVal :
	               hitLevel  ? pinSync :
	               hitLatch  ? latchVal :
	               hitOdrain ? odVal :
	               hitChgEn  ? chgEnVal :
	               hitChgPu  ? chgPuVal : '0;

	wire logic [GPCN_DW-1:0] rdWord = !isBase    ? ALIAS_READ_VAL :
	                                  hitChgCtrl ? (32'(chgOnVal) << CHGCTRL_ON_BIT) :
	                                  {{(GPCN_DW-N){1'b0}}, rdSel};

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= '0;
		else if (rdStb)
			rdata_q <= rdWord;
		else
			rdata_q <= '0;
	end

	assign rdata = rdata_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_irq_cause;
		@(posedge clk) disable iff (!nrst)
		changeIrq |-> $past(chgOnVal[0]) && ($past(pinDelta) != '0);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled change");

	property p_irq_off;
		@(posedge clk) disable iff (!nrst)
		!chgOnVal[0] |=> !changeIrq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while unit off");

	property p_irq_masked;
		@(posedge clk) disable iff (!nrst)
		(chgEnVal == '0) |=> !changeIrq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("irq with no pin enabled");

	property p_pullup;
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> (pullupEn == $past(chgPuVal));
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up not following enable");

	property p_level_inv;
		@(posedge clk) disable iff (!nrst)
		(wrStb && hitLevel && opSel == ALIAS_INV) |=> (latchVal == ($past(pinSync) ^ $past(wdata[N-1:0])));
	endproperty
	a_level_inv: assert property (p_level_inv) else $error("level invert wrong latch");

	property p_input_hiz;
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> ((pinOe & $past(dirVal)) == '0);
	endproperty
	a_input_hiz: assert property (p_input_hiz) else $error("input pin driven");

	property p_od_high;
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> ((pinOe & pinOut & $past(odVal)) == '0);
	endproperty
	a_od_high: assert property (p_od_high) else $error("open-drain drove high");

	property p_upper_zero;
		@(posedge clk) disable iff (!nrst)
		rdStb |=> (rdata[GPCN_DW-1:16] == '0);
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

	property p_alias_read;
		@(posedge clk) disable iff (!nrst)
		(rdStb && !isBase) |=> (rdata == ALIAS_READ_VAL);
	endproperty
	a_alias_read: assert property (p_alias_read) else $error("alias read not fixed");

	property p_level_set;
		@(posedge clk) disable iff (!nrst)
		(wrStb && hitLevel && opSel == ALIAS_SET) |=> (latchVal == ($past(pinSync) | $past(wdata[N-1:0])));
	endproperty
	a_level_set: assert property (p_level_set) else $error("level set wrong latch");

	property p_level_clr;
		@(posedge clk) disable iff (!nrst)
		(wrStb && hitLevel && opSel == ALIAS_CLR) |=> (latchVal == ($past(pinSync) & ~$past(wdata[N-1:0])));
	endproperty
	a_level_clr: assert property (p_level_clr) else $error("level clear wrong latch");

	property p_push_pull;
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> (((pinOe ^ ~$past(dirVal)) & ~$past(odVal)) == '0);
	endproperty
	a_push_pull: assert property (p_push_pull) else $error("push-pull output not driven");

	property p_od_low;
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> (((pinOe ^ (~$past(dirVal) & ~$past(latchVal))) & $past(odVal)) == '0);
	endproperty
	a_od_low: assert property (p_od_low) else $error("open-drain low drive wrong");

	property p_read_dir;
		@(posedge clk) disable iff (!nrst)
		(rdStb && hitDir && isBase) |=> (rdata == {{(GPCN_DW-N){1'b0}}, $past(dirVal)});
	endproperty
	a_read_dir: assert property (p_read_dir) else $error("direction read wrong");

	property p_read_latch;
		@(posedge clk) disable iff (!nrst)
		(rdStb && hitLatch && isBase) |=> (rdata == {{(GPCN_DW-N){1'b0}}, $past(latchVal)});
	endproperty
	a_read_latch: assert property (p_read_latch) else $error("latch read wrong");

	property p_read_level;
		@(posedge clk) disable iff (!nrst)
		(rdStb && hitLevel && isBase) |=> (rdata[N-1:0] == $past(pinSync));
	endproperty
	a_read_level: assert property (p_read_level) else $error("pin level read wrong");

	c_irq:      cover property (@(posedge clk) disable iff (!nrst) changeIrq);
	c_level:    cover property (@(posedge clk) disable iff (!nrst) wrStb && hitLevel && opSel == ALIAS_SET);
	c_odrain:   cover property (@(posedge clk) disable iff (!nrst) (pinOe & ~pinOut) != '0);
	c_dirwrite: cover property (@(posedge clk) disable iff (!nrst) wrStb && hitDir && opSel == ALIAS_CLR);
	c_levelinv: cover property (@(posedge clk) disable iff (!nrst) wrStb && hitLevel && opSel == ALIAS_INV);
endmodule

// *** inc/gpcn_pkg.sv ***
// gpcn_pkg: offsets, widths and reset values for the gpio change-notice port
// assumes a 32-bit word-addressed register port with byte offsets
package gpcn_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int          GPCN_PINS      = 16;
	localparam int          GPCN_CHG_PINS  = 16;
	localparam int          GPCN_AW        = 8;
	localparam int          GPCN_DW        = 32;

	// ----------------------------------------
	// register byte offsets (base, clear, set, invert)
	// ----------------------------------------
	localparam logic [7:0]  OFS_DIR        = 8'h00;
	localparam logic [7:0]  OFS_LEVEL      = 8'h10;
	localparam logic [7:0]  OFS_LATCH      = 8'h20;
	localparam logic [7:0]  OFS_ODRAIN     = 8'h30;
	localparam logic [7:0]  OFS_CHGCTRL    = 8'h40;
	localparam logic [7:0]  OFS_CHGEN      = 8'h50;
	localparam logic [7:0]  OFS_CHGPU      = 8'h60;

	// alias selector in address bits 3:2
	localparam logic [1:0]  ALIAS_BASE     = 2'h0;
	localparam logic [1:0]  ALIAS_CLR      = 2'h1;
	localparam logic [1:0]  ALIAS_SET      = 2'h2;
	localparam logic [1:0]  ALIAS_INV      = 2'h3;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int          CHGCTRL_ON_BIT = 15;

	// ----------------------------------------
	// reset values and alias read value
	// ----------------------------------------
	localparam logic [31:0] RST_DIR        = 32'h0000ffff;
	localparam logic [31:0] RST_ZERO       = 32'h00000000;
	localparam logic [31:0] ALIAS_READ_VAL = 32'h00000000;

	// alias operation on a base value
	typedef enum logic [3:0]
	{
		GPCN_OP_WRITE = 4'b0001,
		GPCN_OP_CLR   = 4'b0010,
		GPCN_OP_SET   = 4'b0100,
		GPCN_OP_INV   = 4'b1000
	} gpcn_op_e;

endpackage

// *** hw/gpcn_alias_reg.sv ***
// gpcn_alias_reg: one register with base write and clear/set/invert aliases
// assumes the top decodes the alias and gives the modify source
`timescale 1ns/10ps
module gpcn_alias_reg
#(
	parameter int          W     = 16,
	parameter logic [31:0] RSTV  = 32'h0
)
(
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         wrEn,
	input  wire logic [1:0]   opSel,
	input  wire logic [W-1:0] src,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] value
);
	import gpcn_pkg::*;

	logic [W-1:0] value_q;
	logic [W-1:0] value_d;

	// ----------------------------------------
	// aliases modify only one-valued positions, base write replaces all
	// ----------------------------------------
	assign value_d = (opSel == ALIAS_CLR) ? (src & ~wdata) :
	                 (opSel == ALIAS_SET) ? (src | wdata) :
	                 (opSel == ALIAS_INV) ? (src ^ wdata) : wdata;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			value_q <= RSTV[W-1:0];
		else if (wrEn)
			value_q <= value_d;
	end

	assign value = value_q;

	property p_alias_set;
		@(posedge clk) disable iff (!nrst)
		(wrEn && opSel == ALIAS_SET) |=> ((value_q & $past(wdata)) == $past(wdata));
	endproperty
	a_alias_set: assert property (p_alias_set) else $error("set alias missed a bit");

	property p_alias_clr_keep;
		@(posedge clk) disable iff (!nrst)
		(wrEn && opSel == ALIAS_CLR) |=> (value_q == ($past(src) & ~$past(wdata)));
	endproperty
	a_alias_clr_keep: assert property (p_alias_clr_keep) else $error("clear alias disturbed bits");
endmodule

// *** hw/gpcn_sync.sv ***
// gpcn_sync: two-flop synchroniser for the pin inputs
// assumes pins are asynchronous to clk
`timescale 1ns/10ps
module gpcn_sync
#(
	parameter int W = 16
)
(
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end

	assign dout = sync_q;
endmodule

// *** dv/gpcn_pin_model.sv ***
// gpcn_pin_model: level on each port pin from all its drivers
// assumes the bench commands the far devices through extEn and extVal
`timescale 1ns/10ps
module gpcn_pin_model
(
	input  wire logic        clk,
	input  wire logic [15:0] pinOut,
	input  wire logic [15:0] pinOe,
	input  wire logic [15:0] pullupEn,
	input  wire logic [15:0] extEn,
	input  wire logic [15:0] extVal,
	output logic      [15:0] pinIn
);
	// ----
	// wire level
	// ----
	logic [15:0] floatPat_q = 16'h0000;
	// undriven pin without pull-up wanders
	always_ff @(posedge clk)
		floatPat_q <= ~floatPat_q;
	// port drive first, then far device, then pull-up
	assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal)
		| (~pinOe & ~extEn & (pullupEn | floatPat_q));
endmodule

// *** dv/gpcn_port_test.sv ***
// gpcn_port_test: self-checking bench for the gpio change-notice port
// assumes gpcn_pin_model on the pins, one-cycle strobe register port
`timescale 1ns/10ps
module gpcn_port_test;
	import gpcn_pkg::*;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic        wrStb = 1'b0;
	logic        rdStb = 1'b0;
	logic [31:0] rdata;
	logic [15:0] pinIn;
	logic [15:0] pinOut;
	logic [15:0] pinOe;
	logic [15:0] pullupEn;
	logic        changeIrq;
	logic [15:0] extEn = 16'hffff;
	logic [15:0] extVal = 16'h0000;
	int          fails = 0;
	int          n_compared = 0;
	int          cycles = 0;

	gpcn_port u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wrStb(wrStb),
		.rdStb(rdStb), .rdata(rdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.pullupEn(pullupEn), .changeIrq(changeIrq));
	gpcn_pin_model u_pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
		.extEn(extEn), .extVal(extVal), .pinIn(pinIn));

	always #20 clk = ~clk;

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			fails++;
			finish_test();
		end
	end

	// ----
	// shared tasks
	// ----
	function automatic logic [7:0] ra(input logic [7:0] o, input logic [1:0] al);
		return o | {4'h0, al, 2'b00};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr  <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		check(what, rdata, exp);
	endtask

	task automatic pulses(input string what, input logic [15:0] flip, input int exp);
		int n = 0;
		@(posedge clk);
		extVal <= extVal ^ flip;
		repeat (8)
		begin
			@(posedge clk);
			#1;
			if (changeIrq === 1'b1)
				n++;
		end
		check(what, n, exp);
	endtask

	task automatic finish_test;
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----
	// scenarios
	// ----
	task automatic test_reset;
		rd_chk("dir", OFS_DIR, RST_DIR);
		check("oe at reset", pinOe, 16'h0000);
		rd_chk("od", OFS_ODRAIN, RST_ZERO);
		wr(8'h70, 32'hffffffff);
		rd_chk("unmapped", 8'h70, RST_ZERO);
	endtask

	task automatic test_alias;
		logic [7:0] offs [5] = '{OFS_DIR, OFS_LATCH, OFS_ODRAIN, OFS_CHGEN, OFS_CHGPU};
		foreach (offs[i])
		begin
			wr(offs[i], 32'hffff1234);
			rd_chk("base", offs[i], 32'h00001234);
			wr(ra(offs[i], ALIAS_CLR), 32'h00000204);
			rd_chk("clear", offs[i], 32'h00001030);
			wr(ra(offs[i], ALIAS_SET), 32'hffff8001);
			rd_chk("set", offs[i], 32'h00009031);
			wr(ra(offs[i], ALIAS_INV), 32'h000000ff);
			rd_chk("invert", offs[i], 32'h000090ce);
			rd_chk("alias read", ra(offs[i], ALIAS_SET), ALIAS_READ_VAL);
			wr(offs[i], (i == 0) ? RST_DIR : RST_ZERO);
		end
		wr(OFS_CHGCTRL, 32'hffffffff);
		rd_chk("control", OFS_CHGCTRL, 32'h00008000);
		wr(ra(OFS_CHGCTRL, ALIAS_CLR), 32'h00008000);
		rd_chk("control clear", OFS_CHGCTRL, RST_ZERO);
	endtask

	task automatic test_drive;
		wr(OFS_LATCH, 32'h00000005);
		wr(OFS_DIR, 32'h0000fffc);
		cyc(1);
		check("oe", pinOe, 16'h0003);
		check("out", pinOut, 16'h0005);
		wr(OFS_ODRAIN, 32'h00000003);
		cyc(1);
		check("od oe", pinOe, 16'h0002);
		check("od out", pinOut, 16'h0004);
		wr(OFS_DIR, RST_DIR);
		wr(OFS_ODRAIN, RST_ZERO);
		wr(OFS_LATCH, RST_ZERO);
	endtask

	task automatic test_rerst;
		wr(OFS_DIR, RST_ZERO);
		wr(OFS_ODRAIN, 32'h0000ffff);
		cyc(1);
		check("oe before reset", pinOe, 16'hffff);
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1;
		check("oe in reset", pinOe, 16'h0000);
		@(posedge clk);
		nrst <= 1'b1;
		rd_chk("dir after reset", OFS_DIR, RST_DIR);
		rd_chk("od after reset", OFS_ODRAIN, RST_ZERO);
	endtask

	task automatic test_level;
		logic [1:0]  al [3] = '{ALIAS_CLR, ALIAS_SET, ALIAS_INV};
		logic [31:0] msk [3] = '{32'h000000c3, 32'h00000f00, 32'h000000ff};
		logic [31:0] exp [3] = '{32'h0000a500, 32'h0000afc3, 32'h0000a53c};
		extVal <= 16'ha5c3;
		cyc(4);
		rd_chk("level", OFS_LEVEL, 32'h0000a5c3);
		foreach (al[i])
		begin
			wr(ra(OFS_LEVEL, al[i]), msk[i]);
			rd_chk("level alias", OFS_LATCH, exp[i]);
		end
		wr(OFS_LEVEL, 32'hffff1234);
		rd_chk("level base", OFS_LATCH, 32'h00001234);
		rd_chk("level pins", OFS_LEVEL, 32'h0000a5c3);
		wr(OFS_LATCH, RST_ZERO);
	endtask

	task automatic test_pullup;
		wr(OFS_CHGPU, 32'h00000001);
		extVal <= 16'h0000;
		extEn  <= 16'hfffe;
		cyc(4);
		check("pull-up en", pullupEn, 16'h0001);
		rd_chk("pulled pin", OFS_LEVEL, 32'h00000001);
		@(posedge clk);
		extEn <= 16'hffff;
		wr(OFS_CHGPU, RST_ZERO);
	endtask

	task automatic test_cn;
		wr(OFS_CHGEN, 32'h00000001);
		wr(OFS_CHGCTRL, 32'h00008000);
		pulses("enabled pin", 16'h0001, 1);
		pulses("other pin", 16'h0002, 0);
		wr(ra(OFS_CHGCTRL, ALIAS_CLR), 32'h00008000);
		pulses("unit off", 16'h0001, 0);
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		test_reset();
		test_alias();
		test_drive();
		test_rerst();
		test_level();
		test_pullup();
		test_cn();
		finish_test();
	end
endmodule
